// file: rtl/output_and_test_pattern_regs.sv
// Operation
// [RL1] Output-disable bit 4: 0 drives data outputs, 1 turns them off.
// [RL2] Output-invert bit 2 set inverts every output sample bit.
// [RL3] Format 00 offset binary, 01 twos complement (reset), 10 Gray; 11 reserved.
// [RL4] Delay enabled: clock delay is 100 ps plus 3100 ps times code over 31.
// [RL5] Pattern one word: low byte at 0x19, high byte at 0x1A.
// [RL6] Pattern two word: low byte at 0x1B, high byte at 0x1C.
// [RL7] Pattern three word: low byte at 0x1D, high byte at 0x1E.
// [RL8] Pattern four word: low byte at 0x1F, high byte at 0x20.
// [RL9] Five-bit full-scale code resets to 00000, passed unchanged to range control.
// [RL10] Open bits ignore writes and read zero; fields read back last write.
`timescale 1ns/1ps
`default_nettype none

module output_and_test_pattern_regs #(
	parameter int SAMPLE_WIDTH = converter_regs_pkg::SAMPLE_WIDTH
) (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    nrst,
	// Serial port pins
	input  wire logic                    sclk,
	input  wire logic                    csb,
	input  wire logic                    sdio_in,
	output var  logic                    sdio_out,
	output var  logic                    sdio_oe,
	// Converter core samples, offset binary
	input  wire logic [SAMPLE_WIDTH-1:0] sample_in,
	// Output port
	output var  logic [SAMPLE_WIDTH-1:0] data_out,
	output var  logic                    data_oe,
	output var  logic                    output_data_clock,
	output var  logic [11:0]             data_clock_delay_ps,
	// Analog controls
	output var  logic [3:0]              drive_strength,
	output var  logic [4:0]              full_scale_code,
	// User test patterns
	output var  logic [15:0]             test_pattern1,
	output var  logic [15:0]             test_pattern2,
	output var  logic [15:0]             test_pattern3,
	output var  logic [15:0]             test_pattern4
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic       sclk_s;
	logic       csb_s;
	logic       sdio_s;
	logic       sclk_prev;

	// Idle levels: clock low, select high, data low
	pin_sync #(
		.WIDTH (3),
		.IDLE  (3'h2)
	) u_pin_sync (
		.clock        (clock),
		.nrst         (nrst),
		.pin_in       ({sclk, csb, sdio_in}),
		.pin_sync_out (pins_s)
	);

	assign sclk_s = pins_s[2];
	assign csb_s  = pins_s[1];
	assign sdio_s = pins_s[0];

	// ----------------------------------------------------------------
	// Serial transfer state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INSTR,
		ST_DATA
	} spi_state_t;

	spi_state_t                                state;
	spi_state_t                                next_state;
	logic [3:0]                                bit_count;
	logic [converter_regs_pkg::INSTR_BITS-1:0] shift_in;
	logic [converter_regs_pkg::ADDR_WIDTH-1:0] addr;
	logic                                      is_read;
	logic [7:0]                                out_shift;

	wire sclk_rise = sclk_s & ~sclk_prev;
	wire sclk_fall = ~sclk_s & sclk_prev;
	wire selected  = ~csb_s;

	wire [converter_regs_pkg::INSTR_BITS-1:0] word_in = {shift_in[14:0], sdio_s};
	wire [7:0] byte_in = word_in[7:0];

	wire instr_done = (state == ST_INSTR) && sclk_rise
		&& (bit_count == converter_regs_pkg::INSTR_LAST_BIT);
	wire byte_done  = (state == ST_DATA) && sclk_rise
		&& (bit_count == converter_regs_pkg::BYTE_LAST_BIT);
	wire instr_read = word_in[converter_regs_pkg::INSTR_READ_BIT];
	wire [converter_regs_pkg::ADDR_WIDTH-1:0] instr_addr =
		word_in[converter_regs_pkg::ADDR_WIDTH-1:0];
	wire [converter_regs_pkg::ADDR_WIDTH-1:0] addr_down =
		addr - {{(converter_regs_pkg::ADDR_WIDTH-1){1'b0}}, 1'b1};

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (selected) begin
					next_state = ST_INSTR;
				end
			end
			ST_INSTR: begin
				if (!selected) begin
					next_state = ST_IDLE;
				end else if (instr_done) begin
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				if (!selected) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state     <= ST_IDLE;
			sclk_prev <= 1'b0;
		end else begin
			state     <= next_state;
			sclk_prev <= sclk_s;
		end
	end

	// Bit counter and input shifter; restart on every deselect
	always_ff @(posedge clock) begin
		if (!nrst || !selected) begin
			bit_count <= 4'h0;
			shift_in  <= 16'h0000;
		end else if (instr_done || byte_done) begin
			bit_count <= 4'h0;
			shift_in  <= word_in;
		end else if (sclk_rise) begin
			bit_count <= bit_count + 4'h1;
			shift_in  <= word_in;
		end
	end

	// Address captured from the instruction, stepping down per byte
	always_ff @(posedge clock) begin
		if (!nrst) begin
			addr    <= 13'h0000;
			is_read <= 1'b0;
		end else if (instr_done) begin
			addr    <= instr_addr;
			is_read <= instr_read;
		end else if (byte_done) begin
			addr    <= addr_down;
		end
	end

	// ----------------------------------------------------------------
	// Register bank
	// ----------------------------------------------------------------
	logic [7:0] bank [converter_regs_pkg::BANK_SIZE];

	// Only whole bytes that land inside the bank are written
	wire write_hit = byte_done && !is_read
		&& (addr >= converter_regs_pkg::BANK_FIRST)
		&& (addr <= converter_regs_pkg::BANK_LAST);
	wire [converter_regs_pkg::ADDR_WIDTH-1:0] write_offset =
		addr - converter_regs_pkg::BANK_FIRST;
	wire [3:0] write_index = write_offset[3:0];

	genvar gi;
	generate
		for (gi = 0; gi < converter_regs_pkg::BANK_SIZE; gi++) begin : g_bank
			always_ff @(posedge clock) begin
				if (!nrst) begin
					bank[gi] <= converter_regs_pkg::RESET_VALUE[gi];
				// [RL10] Open bits masked
				end else if (write_hit && (write_index == 4'(gi))) begin
					bank[gi] <= byte_in & converter_regs_pkg::WRITE_MASK[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read address: instruction address first, then the next lower byte
	wire [converter_regs_pkg::ADDR_WIDTH-1:0] read_addr =
		(state == ST_INSTR) ? instr_addr : addr_down;
	wire read_hit = (read_addr >= converter_regs_pkg::BANK_FIRST)
		&& (read_addr <= converter_regs_pkg::BANK_LAST);
	wire [converter_regs_pkg::ADDR_WIDTH-1:0] read_offset =
		read_addr - converter_regs_pkg::BANK_FIRST;
	// [RL10] Unmapped reads zero
	wire [7:0] read_byte = read_hit ? bank[read_offset[3:0]] : 8'h00;

	// ----------------------------------------------------------------
	// Serial data out
	// ----------------------------------------------------------------
	// Load on the last rise of a byte, shift out on each fall
	always_ff @(posedge clock) begin
		if (!nrst) begin
			out_shift <= 8'h00;
			sdio_out  <= 1'b0;
			sdio_oe   <= 1'b0;
		end else if (!selected) begin
			sdio_oe   <= 1'b0;
		end else if ((instr_done && instr_read) || (byte_done && is_read)) begin
			out_shift <= read_byte;
			sdio_oe   <= 1'b1;
		end else if ((state == ST_DATA) && is_read && sclk_fall) begin
			sdio_out  <= out_shift[7];
			out_shift <= {out_shift[6:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	wire [7:0] cfg   = bank[converter_regs_pkg::IDX_OUTPUT_CONFIG];
	wire [7:0] delay = bank[converter_regs_pkg::IDX_DELAY];

	wire out_disable   = cfg[converter_regs_pkg::OUT_DISABLE_BIT];
	wire out_invert    = cfg[converter_regs_pkg::OUT_INVERT_BIT];
	wire [1:0] fmt_code =
		cfg[converter_regs_pkg::FORMAT_MSB:converter_regs_pkg::FORMAT_LSB];
	wire polarity_flip = bank[converter_regs_pkg::IDX_POLARITY][converter_regs_pkg::POLARITY_FLIP_BIT];
	wire data_clock_delay_on = delay[converter_regs_pkg::DELAY_ON_BIT];
	wire [4:0] delay_code = delay[converter_regs_pkg::DELAY_CODE_MSB:0];

	// ----------------------------------------------------------------
	// Sample formatting
	// ----------------------------------------------------------------
	logic [SAMPLE_WIDTH-1:0] formatted;

	// [RL3] Format select
	always_comb begin
		unique case (converter_regs_pkg::sample_format_t'(fmt_code))
			converter_regs_pkg::FMT_OFFSET_BINARY: formatted = sample_in;
			converter_regs_pkg::FMT_TWOS:
				formatted = {~sample_in[SAMPLE_WIDTH-1], sample_in[SAMPLE_WIDTH-2:0]};
			converter_regs_pkg::FMT_GRAY: formatted = sample_in ^ (sample_in >> 1);
			// Reserved code: pass offset binary
			converter_regs_pkg::FMT_RESERVED: formatted = sample_in;
		endcase
	end

	// [RL2] Invert all bits
	wire [SAMPLE_WIDTH-1:0] next_data = formatted ^ {SAMPLE_WIDTH{out_invert}};

	// ----------------------------------------------------------------
	// Data clock delay and output registers
	// ----------------------------------------------------------------
	localparam int DELAY_WIDTH_L = converter_regs_pkg::DELAY_WIDTH;

	// [RL4] Delay in picoseconds, exact for every code
	wire [DELAY_WIDTH_L-1:0] delay_calc = DELAY_WIDTH_L'(converter_regs_pkg::DELAY_BASE_PS
		+ (converter_regs_pkg::DELAY_SPAN_PS * int'(delay_code)) / converter_regs_pkg::DELAY_CODE_MAX);

	// Divide-by-two phase behind the output data clock
	logic clock_phase;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			data_out            <= '0;
			data_oe             <= 1'b0;
			clock_phase         <= 1'b0;
			output_data_clock   <= 1'b0;
			data_clock_delay_ps <= 12'h000;
		end else begin
			data_out            <= next_data;
			// [RL1] Output disable
			data_oe             <= ~out_disable;
			clock_phase         <= ~clock_phase;
			output_data_clock   <= ~clock_phase ^ polarity_flip;
			// [RL4] Delay when enabled
			data_clock_delay_ps <= data_clock_delay_on ? delay_calc : 12'h000;
		end
	end

	// ----------------------------------------------------------------
	// Analog controls and patterns, straight from the bank
	// ----------------------------------------------------------------
	assign drive_strength  = bank[converter_regs_pkg::IDX_OUTPUT_DRIVE][converter_regs_pkg::DRIVE_MSB:0];
	// [RL9] Span code pass-through
	assign full_scale_code = bank[converter_regs_pkg::IDX_FULL_SCALE][converter_regs_pkg::SPAN_MSB:0];
	// [RL5] Pattern one word
	assign test_pattern1 = {bank[converter_regs_pkg::IDX_PATTERN1_LOW + 1], bank[converter_regs_pkg::IDX_PATTERN1_LOW]};
	// [RL6] Pattern two word
	assign test_pattern2 = {bank[converter_regs_pkg::IDX_PATTERN1_LOW + 3], bank[converter_regs_pkg::IDX_PATTERN1_LOW + 2]};
	// [RL7] Pattern three word
	assign test_pattern3 = {bank[converter_regs_pkg::IDX_PATTERN1_LOW + 5], bank[converter_regs_pkg::IDX_PATTERN1_LOW + 4]};
	// [RL8] Pattern four word
	assign test_pattern4 = {bank[converter_regs_pkg::IDX_PATTERN1_LOW + 7], bank[converter_regs_pkg::IDX_PATTERN1_LOW + 6]};

endmodule

`default_nettype wire

// file: inc/converter_regs_pkg.sv
`default_nettype none

package converter_regs_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SAMPLE_WIDTH = 11;
	localparam int ADDR_WIDTH   = 13;
	localparam int INSTR_BITS   = 16;
	localparam int BANK_SIZE    = 13;
	localparam int INDEX_WIDTH  = 4;
	localparam int DELAY_WIDTH  = 12;

	// ----------------------------------------------------------------
	// Instruction word layout
	// ----------------------------------------------------------------
	localparam int INSTR_READ_BIT = 15;
	localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
	localparam logic [3:0] BYTE_LAST_BIT  = 4'h7;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_WIDTH-1:0] ADDR_OUTPUT_CONFIG       = 13'h0014;
	localparam logic [ADDR_WIDTH-1:0] ADDR_OUTPUT_DRIVE        = 13'h0015;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DATA_CLOCK_POLARITY = 13'h0016;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DATA_CLOCK_DELAY    = 13'h0017;
	localparam logic [ADDR_WIDTH-1:0] ADDR_FULL_SCALE_SELECT   = 13'h0018;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN1_LOW        = 13'h0019;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN1_HIGH       = 13'h001A;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN2_LOW        = 13'h001B;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN2_HIGH       = 13'h001C;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN3_LOW        = 13'h001D;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN3_HIGH       = 13'h001E;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN4_LOW        = 13'h001F;
	localparam logic [ADDR_WIDTH-1:0] ADDR_PATTERN4_HIGH       = 13'h0020;
	localparam logic [ADDR_WIDTH-1:0] BANK_FIRST               = ADDR_OUTPUT_CONFIG;
	localparam logic [ADDR_WIDTH-1:0] BANK_LAST                = ADDR_PATTERN4_HIGH;

	// Bank indices (offset minus first offset)
	localparam int IDX_OUTPUT_CONFIG = 0;
	localparam int IDX_OUTPUT_DRIVE  = 1;
	localparam int IDX_POLARITY      = 2;
	localparam int IDX_DELAY         = 3;
	localparam int IDX_FULL_SCALE    = 4;
	localparam int IDX_PATTERN1_LOW  = 5;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OUT_DISABLE_BIT   = 4;
	localparam int OUT_INVERT_BIT    = 2;
	localparam int FORMAT_MSB        = 1;
	localparam int FORMAT_LSB        = 0;
	localparam int DRIVE_MSB         = 3;
	localparam int POLARITY_FLIP_BIT = 7;
	localparam int DELAY_ON_BIT      = 7;
	localparam int DELAY_CODE_MSB    = 4;
	localparam int SPAN_MSB          = 4;

	// Writable bits and reset values, one entry per bank index
	localparam logic [7:0] WRITE_MASK [BANK_SIZE] = '{
		8'h17, 8'h0F, 8'h80, 8'h9F, 8'h1F, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [7:0] RESET_VALUE [BANK_SIZE] = '{
		8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ----------------------------------------------------------------
	// Sample format codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_OFFSET_BINARY = 2'h0,
		FMT_TWOS          = 2'h1,
		FMT_GRAY          = 2'h2,
		FMT_RESERVED      = 2'h3
	} sample_format_t;

	// ----------------------------------------------------------------
	// Data clock delay, in picoseconds
	// ----------------------------------------------------------------
	localparam int DELAY_BASE_PS = 100;
	localparam int DELAY_SPAN_PS = 3100;
	localparam int DELAY_CODE_MAX = 31;

endpackage

`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             nrst,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			stage1       <= IDLE;
			pin_sync_out <= IDLE;
		end else begin
			stage1       <= pin_in;
			pin_sync_out <= stage1;
		end
	end

endmodule

`default_nettype wire

// file: dv/output_and_test_pattern_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module output_and_test_pattern_regs_chk #(
	parameter int SAMPLE_WIDTH = converter_regs_pkg::SAMPLE_WIDTH
) (
	// Clock and reset
	input wire logic                    clock,
	input wire logic                    nrst,
	// Serial port pins
	input wire logic                    sclk,
	input wire logic                    csb,
	input wire logic                    sdio_in,
	input wire logic                    sdio_out,
	input wire logic                    sdio_oe,
	// Sample path
	input wire logic [SAMPLE_WIDTH-1:0] sample_in,
	input wire logic [SAMPLE_WIDTH-1:0] data_out,
	input wire logic                    data_oe,
	input wire logic                    output_data_clock,
	input wire logic [11:0]             data_clock_delay_ps,
	// Register outputs
	input wire logic [3:0]              drive_strength,
	input wire logic [4:0]              full_scale_code,
	input wire logic [15:0]             test_pattern1,
	input wire logic [15:0]             test_pattern2,
	input wire logic [15:0]             test_pattern3,
	input wire logic [15:0]             test_pattern4
);
	// ----------------------------------------------------------------
	// Settling counter after reset
	// ----------------------------------------------------------------
	logic [1:0] up_cnt;

	always_ff @(posedge clock) begin
		if (!nrst)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	delay_range_a: assert property (
		data_clock_delay_ps == 12'h000 || (data_clock_delay_ps >= 12'h064 &&
		data_clock_delay_ps <= 12'hC80 && data_clock_delay_ps % 12'h064 == 12'h000))
		else $error("data clock delay off its step grid");
	reset_values_a: assert property (
		$rose(nrst) |-> full_scale_code == 5'h00 && drive_strength == 4'h1 && !data_oe &&
		(test_pattern1 | test_pattern2 | test_pattern3 | test_pattern4) == 16'h0000)
		else $error("register outputs not at reset values");
	pattern_hold_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 |=> $stable(test_pattern1) && $stable(test_pattern2) &&
		$stable(test_pattern3) && $stable(test_pattern4))
		else $error("test pattern changed with serial port idle");
	control_hold_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 |=> $stable(full_scale_code) && $stable(drive_strength) &&
		$stable(data_clock_delay_ps))
		else $error("control output changed with serial port idle");
	enable_hold_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 |=> $stable(data_oe))
		else $error("output enable changed with serial port idle");
	data_follow_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 ##0 $stable(sample_in) |=> $stable(data_out))
		else $error("data out moved with steady sample");
	data_change_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 ##0 $changed(sample_in) |=> $changed(data_out))
		else $error("data out missed a sample change");
	sdio_quiet_a: assert property (
		csb[*5] |-> !sdio_oe)
		else $error("serial data driven while deselected");
	data_clock_toggle_a: assert property (
		csb[*8] ##0 up_cnt == 2'h3 |=> $changed(output_data_clock))
		else $error("output data clock missed a toggle");
endmodule

bind output_and_test_pattern_regs output_and_test_pattern_regs_chk #(
	.SAMPLE_WIDTH(SAMPLE_WIDTH)
) u_output_and_test_pattern_regs_chk (
	.clock, .nrst, .sclk, .csb, .sdio_in, .sdio_out, .sdio_oe, .sample_in, .data_out,
	.data_oe, .output_data_clock, .data_clock_delay_ps, .drive_strength, .full_scale_code,
	.test_pattern1, .test_pattern2, .test_pattern3, .test_pattern4
);

`default_nettype wire

// file: dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Clock
	input  wire logic clock,
	// Serial pins
	output var  logic sclk,
	output var  logic csb,
	output var  logic host_sdio,
	input  wire logic sdio_line
);
	localparam int HALF = 8;

	initial begin
		sclk = 1'b0;
		csb = 1'b1;
		host_sdio = 1'b0;
	end

	// One instruction and one data byte; host flips its level and keeps driving while the device answers
	task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [23:0] word;
		word = {rd, 2'h0, addr, wdata};
		rdata = 8'h00;
		@(negedge clock);
		csb = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			if (!rd || i > 7)
				host_sdio = word[i];
			else if (i == 7)
				host_sdio = ~host_sdio;
			repeat (HALF) @(negedge clock);
			sclk = 1'b1;
			if (i < 8)
				rdata[i] = sdio_line;
			repeat (HALF) @(negedge clock);
			sclk = 1'b0;
		end
		repeat (HALF) @(negedge clock);
		csb = 1'b1;
		host_sdio = ~host_sdio;
		repeat (2 * HALF) @(negedge clock);
	endtask
endmodule

`default_nettype wire

// file: dv/output_and_test_pattern_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module output_and_test_pattern_regs_bench;
	localparam int SW = converter_regs_pkg::SAMPLE_WIDTH;
	logic             clock = 1'b0;
	logic             nrst = 1'b0;
	logic [SW-1:0]    sample_in = '0;
	wire logic        sclk, csb, host_sdio, sdio_line, sdio_out, sdio_oe, data_oe, odc;
	wire logic [SW-1:0] data_out;
	wire logic [11:0] delay_ps;
	wire logic [3:0]  drive;
	wire logic [4:0]  span;
	wire logic [15:0] tp1, tp2, tp3, tp4;
	int               error_cnt = 0;
	int               n_compared = 0;
	int               cycles = 0;
	logic [7:0]       rd;
	logic [7:0]       shadow [14];

	always #10 clock = ~clock;
	assign sdio_line = sdio_oe ? sdio_out : host_sdio;

	output_and_test_pattern_regs u_output_and_test_pattern_regs (
		.clock(clock), .nrst(nrst), .sclk(sclk), .csb(csb), .sdio_in(sdio_line),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample_in(sample_in), .data_out(data_out),
		.data_oe(data_oe), .output_data_clock(odc), .data_clock_delay_ps(delay_ps),
		.drive_strength(drive), .full_scale_code(span), .test_pattern1(tp1),
		.test_pattern2(tp2), .test_pattern3(tp3), .test_pattern4(tp4));
	spi_host_model u_spi_host_model (
		.clock(clock), .sclk(sclk), .csb(csb), .host_sdio(host_sdio), .sdio_line(sdio_line));

	// ----------------------------------------------------------------
	// Expectations and reporting
	// ----------------------------------------------------------------
	function automatic logic [7:0] mask_of(input int idx);
		case (idx)
			0: return 8'h17;
			1: return 8'h0F;
			2: return 8'h80;
			3: return 8'h9F;
			4: return 8'h1F;
			default: return 8'hFF;
		endcase
	endfunction

	function automatic logic [SW-1:0] expect_out(input logic [7:0] cfg, input logic [SW-1:0] s);
		logic [SW-1:0] v;
		case (cfg[1:0])
			2'h1: v = {~s[SW-1], s[SW-2:0]};
			2'h2: v = s ^ (s >> 1);
			default: v = s;
		endcase
		return cfg[2] ? ~v : v;
	endfunction

	function automatic logic [15:0] delay_of(input logic [7:0] d);
		return d[7] ? 16'h0064 + 16'h0064 * d[4:0] : 16'h0000;
	endfunction

	task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_port(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			error_cnt++;
			$display("BAD timeout expected done seen running");
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] cfg;
		void'($urandom(32'hE4BD));
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		repeat (4) @(negedge clock);
		for (int i = -1; i <= 13; i++) begin
			u_spi_host_model.xfer(1'b1, 13'h0014 + 13'(i), 8'h00, rd);
			check_reg("reset read", (i == 0 || i == 1) ? 8'h01 : 8'h00, rd);
		end
		$display("test reset values done");
		shadow[13] = 8'h00;
		for (int i = 0; i < 13; i++) begin
			v = 8'($urandom);
			if (i == 0 && v[1:0] == 2'h3)
				v[1] = 1'b0;
			shadow[i] = v & mask_of(i);
			u_spi_host_model.xfer(1'b0, 13'h0014 + 13'(i), v, rd);
		end
		u_spi_host_model.xfer(1'b0, 13'h0021, 8'hA5, rd);
		for (int i = 0; i < 14; i++) begin
			u_spi_host_model.xfer(1'b1, 13'h0014 + 13'(i), 8'h00, rd);
			check_reg("readback", shadow[i], rd);
		end
		check_port("pattern1", {shadow[6], shadow[5]}, tp1);
		check_port("pattern2", {shadow[8], shadow[7]}, tp2);
		check_port("pattern3", {shadow[10], shadow[9]}, tp3);
		check_port("pattern4", {shadow[12], shadow[11]}, tp4);
		check_port("span", {11'h000, shadow[4][4:0]}, {11'h000, span});
		check_port("drive", {12'h000, shadow[1][3:0]}, {12'h000, drive});
		$display("test write readback done");
		foreach (shadow[j]) begin
			v = (j == 0) ? 8'h80 : (j == 1) ? 8'h9F : (j == 2) ? 8'h1F : 8'($urandom);
			u_spi_host_model.xfer(1'b0, 13'h0017, v, rd);
			check_port("delay", delay_of(v & 8'h9F), {4'h0, delay_ps});
		end
		$display("test clock delay done");
		for (int k = 0; k < 12; k++) begin
			cfg = {3'h0, 1'(k / 6), 1'b0, 1'((k / 3) % 2), 2'(k % 3)};
			u_spi_host_model.xfer(1'b0, 13'h0014, cfg, rd);
			for (int j = 0; j < 4; j++) begin
				sample_in = (j == 0) ? '0 : (j == 1) ? '1 : SW'($urandom);
				@(negedge clock);
				check_port("data_out", 16'(expect_out(cfg, sample_in)), 16'(data_out));
			end
			check_port("data_oe", 16'(!cfg[4]), 16'(data_oe));
		end
		$display("test output path done");
		print_verdict();
	end
endmodule

`default_nettype wire
